// File: src/qdsl_pkg.sv
// shared constants for the quad converter serial load path
package qdsl_pkg;
    // word widths of the two resolution variants
    localparam int WORD_W_HI = 16; // 12-bit converter word
    localparam int WORD_W_LO = 14; // 10-bit converter word
    localparam int BYTE_W = 8; // unit width of byte-wise hosts
    localparam int NUM_CH = 4; // converter channels
    localparam int CH_SEL_W = 2; // channel select width
    localparam int CTRL_BITS = 4; // control bits above the data code
    // control field positions, counted down from the word's top bit
    localparam int SHDN_ALL_OFS = 1; // shutdown_all_bit at W-1
    localparam int SHDN_ONE_OFS = 2; // shutdown_one_bit at W-2
    localparam int SEL_HI_OFS = 3; // channel_select_hi at W-3
    localparam int SEL_LO_OFS = 4; // channel_select_lo at W-4
    // reset values
    localparam logic ZERO_CODE_BIT = 1'b0; // every code bit after reset
    localparam logic PIN_IDLE_HI = 1'b1; // idle level of active-low pins
    // timing, in ns and derived in clk_sys cycles
    localparam int CLK_SYS_NS = 20; // 50 MHz system clock
    localparam int SCLK_HALF_NS = 40; // serial clock half period
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
    localparam int BYTE_GAP_NS = 160; // idle gap between two bytes
    localparam int BYTE_GAP_CYC = (BYTE_GAP_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
    localparam int CS_HIGH_NS = 160; // least chip select high time
    localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
    localparam int LOAD_LOW_NS = 100; // load strobe low pulse width
    localparam int LOAD_LOW_CYC = (LOAD_LOW_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
    localparam int CNT_W = 8; // width of host timing counters

    // channel number held in a word of width w
    function automatic logic [CH_SEL_W-1:0] qdsl_sel(input logic [WORD_W_HI-1:0] word,
                                                     input int w);
        qdsl_sel = {word[w-SEL_HI_OFS], word[w-SEL_LO_OFS]};
    endfunction
endpackage

// File: src/qdsl_link_if.sv
`timescale 1ns/10ps
// the three-wire serial link plus the two side pins
interface qdsl_link_if;
    logic sclk; // serial clock, idle low, made by the host
    logic cs_n; // chip select, active low
    logic serial_in_line; // serial data, msb first
    logic load_outputs_strobe_n; // level load of all outputs, active low
    logic async_zero_reset_n; // asynchronous clear to zero code, active low

    modport host (
        output sclk,
        output cs_n,
        output serial_in_line,
        output load_outputs_strobe_n,
        output async_zero_reset_n
    );
    modport dev (
        input sclk,
        input cs_n,
        input serial_in_line,
        input load_outputs_strobe_n,
        input async_zero_reset_n
    );
endinterface

// File: src/qdsl_host.sv
`timescale 1ns/10ps
// How it works
// - word is 16 bits, or 14 bits
// - most significant bit travels first
// - data sampled on rising serial clock
// - shifting only while chip select low
// - only last word-width bits are used
// - host may send two right-justified bytes
// - chip select rise loads addressed channel
// - zero reset pin clears codes asynchronously
// - power-up reset clears all channel registers
// - outputs stay zero until a load
// - update automatic or by load strobe
// - host clock idles low, rising-edge data
// - top bit shuts all channels down
// - next bit shuts only addressed channel
// serial master: makes sclk by dividing clk_sys, shifts one word per start
module qdsl_host import qdsl_pkg::*; #(
    parameter int WORD_W = WORD_W_HI, // 16 or 14
    parameter bit BYTE_MODE = 1'b0, // send as two right-justified bytes
    parameter int HALF_CYC = SCLK_HALF_CYC, // clk_sys cycles per sclk half
    parameter int GAP_CYC = BYTE_GAP_CYC, // idle cycles between the bytes
    parameter int CSH_CYC = CS_HIGH_CYC, // cycles cs_n stays high after a word
    parameter int LDL_CYC = LOAD_LOW_CYC // cycles of one load pulse
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic clk_en, // freezes all state but the done pulse while low
    input wire logic start, // pulse: send word_in
    input wire logic [WORD_W-1:0] word_in, // word to send
    input wire logic load_req, // pulse: strobe load of all outputs
    input wire logic zero_req, // level: hold the device at zero code
    output logic busy, // word in flight
    output logic done, // pulse: word sent and cs_n back high
    qdsl_link_if.host link // serial pins
);
    localparam int SH_W = 2 * BYTE_W; // shifter holds two bytes
    localparam int FRAME_W = BYTE_MODE ? SH_W : WORD_W; // bits per frame

    typedef enum logic [2:0] {
        H_IDLE = 3'h0, // cs_n high, waiting
        H_LOW = 3'h1, // sclk low half, data set up
        H_HIGH = 3'h2, // sclk high half, device samples
        H_GAP = 3'h3, // between the two bytes, cs_n still low
        H_TAIL = 3'h4, // last half before cs_n rises
        H_HOLD = 3'h5 // cs_n high, least high time
    } qdsl_hstate_t;

    typedef struct packed {
        qdsl_hstate_t st; // sequencer state
        logic [CNT_W-1:0] cnt; // half-period, gap and hold timer
        logic [CNT_W-1:0] bits; // bits still to send
        logic [SH_W-1:0] sh; // outgoing shifter, msb at the top
        logic sclk; // serial clock pin
        logic cs_n; // chip select pin
        logic sdo; // serial data pin
        logic ld_n; // load strobe pin
        logic [CNT_W-1:0] ld_cnt; // load pulse timer
        logic zr_n; // zero reset pin
        logic busy; // frame in flight
        logic done; // end of frame pulse
    } qdsl_host_t;

    qdsl_host_t cur, nxt;

    // sequencer and pin drivers
    always_comb begin
        nxt = cur;
        nxt.done = 1'b0;
        if (clk_en) begin
            nxt.zr_n = ~zero_req; // plain level out of a flop
            // load strobe pulse, retriggered by a new request
            if (load_req) begin
                nxt.ld_n = 1'b0;
                nxt.ld_cnt = CNT_W'(LDL_CYC - 1);
            end else if (!cur.ld_n) begin
                if (cur.ld_cnt == '0) begin
                    nxt.ld_n = 1'b1;
                end else begin
                    nxt.ld_cnt = cur.ld_cnt - 1'b1;
                end
            end
            unique case (cur.st)
                H_IDLE: begin
                    if (start) begin
                        // word right-justified, then moved to the top, msb first
                        nxt.sh = SH_W'(word_in) << (SH_W - FRAME_W);
                        nxt.sdo = nxt.sh[SH_W-1];
                        nxt.cs_n = 1'b0;
                        nxt.bits = CNT_W'(FRAME_W);
                        nxt.cnt = CNT_W'(HALF_CYC - 1);
                        nxt.busy = 1'b1;
                        nxt.st = H_LOW;
                    end
                end
                H_LOW: begin
                    if (cur.cnt == '0) begin
                        nxt.sclk = 1'b1; // rising edge with data already stable
                        nxt.cnt = CNT_W'(HALF_CYC - 1);
                        nxt.st = H_HIGH;
                    end else begin
                        nxt.cnt = cur.cnt - 1'b1;
                    end
                end
                H_HIGH: begin
                    if (cur.cnt == '0) begin
                        nxt.sclk = 1'b0; // idle low, data moves on the fall
                        nxt.bits = cur.bits - 1'b1;
                        nxt.sh = cur.sh << 1;
                        nxt.sdo = cur.sh[SH_W-2];
                        nxt.cnt = CNT_W'(HALF_CYC - 1);
                        if (cur.bits == CNT_W'(1)) begin
                            nxt.st = H_TAIL;
                        end else if (BYTE_MODE && cur.bits == CNT_W'(BYTE_W + 1)) begin
                            // cs_n kept low across the byte boundary
                            nxt.cnt = CNT_W'(GAP_CYC - 1);
                            nxt.st = H_GAP;
                        end else begin
                            nxt.st = H_LOW;
                        end
                    end else begin
                        nxt.cnt = cur.cnt - 1'b1;
                    end
                end
                H_GAP: begin
                    if (cur.cnt == '0) begin
                        nxt.cnt = CNT_W'(HALF_CYC - 1);
                        nxt.st = H_LOW;
                    end else begin
                        nxt.cnt = cur.cnt - 1'b1;
                    end
                end
                H_TAIL: begin
                    if (cur.cnt == '0) begin
                        nxt.cs_n = 1'b1; // this edge commits the word
                        nxt.cnt = CNT_W'(CSH_CYC - 1);
                        nxt.st = H_HOLD;
                    end else begin
                        nxt.cnt = cur.cnt - 1'b1;
                    end
                end
                H_HOLD: begin
                    // device needs this time to pick the word up
                    if (cur.cnt == '0) begin
                        nxt.busy = 1'b0;
                        nxt.done = 1'b1;
                        nxt.st = H_IDLE;
                    end else begin
                        nxt.cnt = cur.cnt - 1'b1;
                    end
                end
                default: begin
                    nxt.st = H_IDLE; // unused codes recover to idle
                end
            endcase
        end
    end

    // state register, pins idle high where active low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
            cur.cs_n <= PIN_IDLE_HI;
            cur.ld_n <= PIN_IDLE_HI;
            cur.zr_n <= PIN_IDLE_HI;
        end else begin
            cur <= nxt;
        end
    end

    assign link.sclk = cur.sclk;
    assign link.cs_n = cur.cs_n;
    assign link.serial_in_line = cur.sdo;
    assign link.load_outputs_strobe_n = cur.ld_n;
    assign link.async_zero_reset_n = cur.zr_n;
    assign busy = cur.busy;
    assign done = cur.done;
endmodule

// File: src/qdsl_dev.sv
`timescale 1ns/10ps
module qdsl_dev import qdsl_pkg::*; #(
    parameter int WORD_W = WORD_W_HI // 16 for 12-bit codes, 14 for 10-bit
) (
    input wire logic clk_sys, // system clock for the channel registers
    input wire logic rst_n, // power-on reset, async, active low
    input wire logic clk_en, // freezes system-side state while low, except that the loaded pulse still clears
    input wire logic auto_update, // 1: word goes straight to its output
    qdsl_link_if.dev link, // serial pins, sclk clocks the shifter
    output logic [NUM_CH-1:0][WORD_W-CTRL_BITS-1:0] dac_code, // codes at the outputs
    output logic [NUM_CH-1:0] dac_shutdown, // per-channel power down
    output logic word_loaded // pulse: a word reached its input register
);
    localparam int DW = WORD_W - CTRL_BITS; // code width, 12 or 10

    // ---- link side, clocked by sclk ----

    // only the shifter lives here; sclk may stop outside frames
    typedef struct packed {
        logic [WORD_W-1:0] sh; // serial input shift register
    } qdsl_dev_link_t;

    qdsl_dev_link_t lcur, lnxt;

    // shift one bit in per rising sclk edge inside a frame
    always_comb begin
        lnxt = lcur;
        if (!link.cs_n) begin
            // older bits fall off the top, so the last word stays
            lnxt.sh = {lcur.sh[WORD_W-2:0], link.serial_in_line};
        end
    end

    // sclk-domain register; data is launched on the fall by the host
    always_ff @(posedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            lcur <= '0;
        end else begin
            lcur <= lnxt;
        end
    end

    // ---- system side, clocked by clk_sys ----

    typedef struct packed {
        logic csl_s1; // chip select active, first sync stage
        logic csl_s2; // second sync stage
        logic csl_s3; // delayed copy for edge detect
        logic ld_s1; // load strobe active, first sync stage
        logic ld_s2; // second sync stage
        logic [NUM_CH-1:0][DW-1:0] in_reg; // input registers
        logic [NUM_CH-1:0][DW-1:0] dac_reg; // conversion registers
        logic [NUM_CH-1:0] shdn; // shutdown per channel
        logic loaded; // word taken this cycle
    } qdsl_dev_sys_t;

    qdsl_dev_sys_t cur, nxt;

    logic clr_n; // power-on or pin reset, either clears the codes
    logic cs_rise; // chip select just returned high
    logic [WORD_W-1:0] word; // the committed word
    logic [CH_SEL_W-1:0] ch; // channel addressed by the word
    logic [DW-1:0] code; // data field of the word

    // zero reset wins over every load because it clears asynchronously
    assign clr_n = rst_n & link.async_zero_reset_n;

    // the shifter is read across domains only while cs_n is high:
    // sclk edges are ignored then, so the word is frozen
    assign word = lcur.sh;
    assign ch = qdsl_sel(WORD_W_HI'(word), WORD_W);
    assign code = word[DW-1:0];
    assign cs_rise = cur.csl_s3 & ~cur.csl_s2;

    // decode, channel load and output update
    always_comb begin
        nxt = cur;
        nxt.loaded = 1'b0;
        if (clk_en) begin
            // two-stage syncs; inverted so reset means idle
            nxt.csl_s1 = ~link.cs_n;
            nxt.csl_s2 = cur.csl_s1;
            nxt.csl_s3 = cur.csl_s2;
            nxt.ld_s1 = ~link.load_outputs_strobe_n;
            nxt.ld_s2 = cur.ld_s1;
            if (cs_rise) begin
                // end of frame: commit to the addressed channel
                nxt.in_reg[ch] = code;
                nxt.loaded = 1'b1;
                if (word[WORD_W-SHDN_ALL_OFS]) begin
                    nxt.shdn = '1;
                end else if (word[WORD_W-SHDN_ONE_OFS]) begin
                    nxt.shdn[ch] = 1'b1;
                end else begin
                    nxt.shdn[ch] = 1'b0; // plain write wakes the channel
                end
                if (auto_update) begin
                    nxt.dac_reg[ch] = code;
                end
            end
            // level-sensitive: all four move together
            if (cur.ld_s2) begin
                nxt.dac_reg = nxt.in_reg;
            end
        end
    end

    // one register for the whole system side; zero code out of reset
    always_ff @(posedge clk_sys or negedge clr_n) begin
        if (!clr_n) begin
            cur <= '0;
        end else begin
            cur <= nxt; // codes change only through a load
        end
    end

    // outputs straight from flops
    assign dac_code = cur.dac_reg;
    assign dac_shutdown = cur.shdn;
    assign word_loaded = cur.loaded;
endmodule

// File: dv/qdsl_link_props.sv
`timescale 1ns/10ps
// watches the serial pins between the host end and the device end
module qdsl_link_props (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // reset, active low
    input wire logic sclk, // serial clock
    input wire logic cs_n, // chip select, active low
    input wire logic serial_in_line, // serial data
    input wire logic load_outputs_strobe_n, // load strobe, active low
    input wire logic async_zero_reset_n // zero reset pin, active low
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    logic sclk_q; // sclk one sample back
    logic [4:0] bit_cnt; // rising sclk seen in this frame
    // count rises per frame; cleared while deselected so the count is per frame
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
            bit_cnt <= 5'h00;
        end else begin
            sclk_q <= sclk;
            bit_cnt <= cs_n ? 5'h00 : bit_cnt + 5'((sclk && !sclk_q) ? 1 : 0);
        end
    end
    sequence frame_open;
        $fell(cs_n) ##0 !sclk;
    endsequence
    sequence first_rise;
        ##[1:4] sclk;
    endsequence
    chk_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("serial clock high while deselected");
    chk_data_stable: assert property ($rose(sclk) |-> $stable(serial_in_line))
        else $error("data moved at rising serial clock");
    chk_word_bits: assert property ($rose(cs_n) |-> bit_cnt == 5'h10)
        else $error("frame did not carry sixteen clocks");
    chk_cs_high_min: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("chip select high time too short");
    chk_frame_start: assert property (frame_open |-> first_rise)
        else $error("frame opened without a timely first clock");
    chk_frame_close: assert property ($rose(cs_n) |-> !$past(sclk))
        else $error("chip select rose with clock high");
    chk_load_width: assert property ($fell(load_outputs_strobe_n) |-> !load_outputs_strobe_n [*3])
        else $error("load strobe pulse too short");
    chk_load_release: assert property ($fell(load_outputs_strobe_n) |-> ##[3:40] load_outputs_strobe_n)
        else $error("load strobe stuck low");
    cov_zero: cover property ($fell(async_zero_reset_n));
endmodule

// File: dv/tb.sv
`timescale 1ns/10ps
// host end drives device end; scoreboard checks each committed word
module tb import qdsl_pkg::*;;
    typedef struct packed {
        logic [1:0] ch;
        logic [11:0] code;
        logic [3:0] shd;
    } qdsl_exp_t;
    logic clk_sys = 1'b0; // 50 MHz system clock
    logic rst_n = 1'b0; // reset, active low
    logic start = 1'b0; // send request
    logic [15:0] word_in = 16'h0000; // word to send
    logic load_req = 1'b0; // load strobe request
    logic zero_req = 1'b0; // zero reset request
    logic auto_update = 1'b1; // direct update mode
    logic clk_en = 1'b1; // clock enable of both ends
    logic busy; // host busy
    logic done; // host done pulse
    logic [3:0][11:0] dac_code; // channel outputs
    logic [3:0] dac_shutdown; // shutdown flags
    logic word_loaded; // commit pulse
    int errors = 0; // mismatches
    int compares = 0; // comparisons made
    logic [31:0] seed = 32'h3897; // xorshift state
    qdsl_exp_t exp_q[$]; // expected commits, oldest first
    qdsl_exp_t mon_e; // note taken by the monitor
    logic [11:0] inreg[4] = '{default: 12'h000}; // model input registers
    logic [11:0] outr[4] = '{default: 12'h000}; // model outputs
    logic [3:0] shd = 4'h0; // model shutdown flags
    always #10 clk_sys = ~clk_sys;
    qdsl_link_if qdsl_link_if_i ();
    qdsl_host #(.HALF_CYC(1), .GAP_CYC(2), .CSH_CYC(4), .LDL_CYC(3)) qdsl_host_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .start(start), .word_in(word_in),
        .load_req(load_req), .zero_req(zero_req), .busy(busy), .done(done),
        .link(qdsl_link_if_i.host));
    qdsl_dev qdsl_dev_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .auto_update(auto_update),
        .link(qdsl_link_if_i.dev), .dac_code(dac_code), .dac_shutdown(dac_shutdown),
        .word_loaded(word_loaded));
    qdsl_link_props qdsl_link_props_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .sclk(qdsl_link_if_i.sclk),
        .cs_n(qdsl_link_if_i.cs_n), .serial_in_line(qdsl_link_if_i.serial_in_line),
        .load_outputs_strobe_n(qdsl_link_if_i.load_outputs_strobe_n),
        .async_zero_reset_n(qdsl_link_if_i.async_zero_reset_n));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    endfunction
    task automatic cmp_code(input logic [11:0] got, input logic [11:0] want);
        compares++;
        if (got !== want) begin
            errors++;
            $display("mismatch at %0t: code %h expected %h", $time, got, want);
        end
    endtask
    task automatic cmp_shd(input logic [3:0] got, input logic [3:0] want);
        compares++;
        if (got !== want) begin
            errors++;
            $display("mismatch at %0t: shutdown %h expected %h", $time, got, want);
        end
    endtask
    task automatic finish_test();
        // a note left over means a word never reached its channel
        if (exp_q.size() != 0) begin
            errors++;
            $display("mismatch at %0t: %0d commits never seen", $time, exp_q.size());
        end
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // note the expected commit, then hand the word to the host
    task automatic send(input logic [15:0] w);
        logic [1:0] ch;
        qdsl_exp_t e;
        ch = {w[13], w[12]};
        if (w[15]) begin
            shd = 4'hf;
        end else begin
            shd[ch] = w[14];
        end
        inreg[ch] = w[11:0];
        if (auto_update) begin
            outr[ch] = w[11:0];
        end
        e = '{ch: ch, code: outr[ch], shd: shd};
        exp_q.push_back(e);
        @(posedge clk_sys) start <= 1'b1;
        word_in <= w;
        @(posedge clk_sys) start <= 1'b0;
        do @(negedge clk_sys); while (done !== 1'b1);
    endtask
    // compare every output against the model at a settled point
    task automatic check_all();
        @(negedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            cmp_code(dac_code[i], outr[i]);
        end
        cmp_shd(dac_shutdown, shd);
    endtask
    // scoreboard side: one note per commit pulse
    always @(negedge clk_sys) begin
        if (word_loaded === 1'b1) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("mismatch at %0t: unexpected commit", $time);
            end else begin
                mon_e = exp_q.pop_front();
                cmp_code(dac_code[mon_e.ch], mon_e.code);
                cmp_shd(dac_shutdown, mon_e.shd);
            end
        end
    end
    // hang guard, well beyond the roughly 900 cycles the run needs
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        $display("mismatch at %0t: run timed out", $time);
        finish_test();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        check_all();
        // direct update, random channel and control bits
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            send({(i % 4 == 3) & seed[15], seed[14:0]});
        end
        // strobe mode: outputs hold until the strobe copies all four
        @(posedge clk_sys) auto_update <= 1'b0;
        @(posedge clk_sys);
        for (int c = 0; c < 4; c++) begin
            seed = xs(seed);
            send({2'b00, 2'(c), seed[11:0]});
        end
        // a strobe asked for while frozen is dropped, outputs hold
        @(posedge clk_sys) clk_en <= 1'b0;
        @(posedge clk_sys) load_req <= 1'b1;
        @(posedge clk_sys) load_req <= 1'b0;
        repeat (12) @(posedge clk_sys);
        check_all();
        @(posedge clk_sys) clk_en <= 1'b1;
        @(posedge clk_sys) load_req <= 1'b1;
        @(posedge clk_sys) load_req <= 1'b0;
        repeat (12) @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            outr[i] = inreg[i];
        end
        check_all();
        // zero reset pin clears codes, input registers and shutdown flags while the link is idle
        @(posedge clk_sys) zero_req <= 1'b1;
        repeat (6) @(posedge clk_sys);
        outr = '{default: 12'h000};
        inreg = '{default: 12'h000};
        shd = 4'h0;
        check_all();
        @(posedge clk_sys) zero_req <= 1'b0;
        repeat (6) @(posedge clk_sys);
        // once the pin lets go, a plain load must work again
        auto_update <= 1'b1;
        @(posedge clk_sys);
        seed = xs(seed);
        send({2'h0, seed[13:0]});
        check_all();
        finish_test();
    end
endmodule
